// *** rate_sched_pkg.sv ***
// Purpose: Shared constants and carrier types for the conversion rate scheduler
// Assumes: 250 MHz system clock
// Notes: Register pointers are byte pointers of the serial register file
package rate_sched_pkg;

    // ------------------------------------------------------------
    // Register pointers and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] PTR_STOP_CTRL = 8'h09;
    localparam logic [7:0] PTR_CHAN_ENABLE = 8'h0A;
    localparam logic [7:0] PTR_INTERVAL = 8'h0B;
    localparam logic [7:0] PTR_ONE_SHOT = 8'h0F;
    localparam logic [7:0] RST_STOP_CTRL = 8'h00;
    localparam logic [7:0] RST_CHAN_ENABLE = 8'h7C;
    localparam logic [7:0] RST_INTERVAL = 8'h07;
    localparam logic [7:0] INTERVAL_MASK = 8'h07;
    localparam logic [7:0] STOP_CTRL_MASK = 8'h44;
    localparam logic [7:0] CHAN_ENABLE_MASK = 8'h7C;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int STOP_BIT = 6;
    localparam int LOCAL_ON_BIT = 3;
    localparam int NUM_CHANNELS = 4;

    // ------------------------------------------------------------
    // Timing: one channel conversion and the slowest sequence period
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 250;
    // One channel takes an eighth of a second, so 8/s holds only for one channel
    localparam int CONV_TIME_US = 125000;
    localparam int CONV_CYCLES = CONV_TIME_US * CLK_MHZ;
    localparam int SLOWEST_PERIOD_MS = 16000;
    localparam longint SLOWEST_PERIOD_CYCLES = longint'(SLOWEST_PERIOD_MS) * 1000 * CLK_MHZ;
    localparam int CNT_W = 32;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONVERT = 2'b01,
        ST_WAIT = 2'b10
    } sched_state_type;

    typedef struct packed {
        logic write;
        logic read;
        logic [7:0] pointer;
        logic [7:0] wdata;
    } reg_req_type;

    typedef struct packed {
        logic busy;
        logic start;
        logic [1:0] channel;
        logic done;
    } conv_ctrl_type;

endpackage

// *** period_timer.sv ***
// Purpose: Loadable down counter, pulses when a programmed count elapses
// Assumes: Load and run come from logic on the same clock
// Notes: Count of zero expires on the next enabled edge
`timescale 1ns/1ns
`default_nettype none
module period_timer (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_load,
    input wire logic [rate_sched_pkg::CNT_W-1:0] i_count,
    input wire logic i_abort,
    output logic o_expired,
    output logic o_running
);
    logic [rate_sched_pkg::CNT_W-1:0] remaining;

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            remaining <= '0;
            o_running <= 1'b0;
            o_expired <= 1'b0;
        end else if (i_ce) begin
            o_expired <= 1'b0;
            if (i_abort) begin
                o_running <= 1'b0;
            end else if (i_load) begin
                remaining <= i_count;
                o_running <= 1'b1;
            end else if (o_running) begin
                if (remaining <= 1) begin
                    o_running <= 1'b0;
                    o_expired <= 1'b1;
                end else begin
                    remaining <= remaining - 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** conversion_rate_scheduler.sv ***
// Purpose: Schedules channel conversions and idle gaps from the interval register
// Assumes: Serial protocol engine delivers decoded register accesses on i_sys_clk
// Notes: Converter is outside; this block only times and sequences it
// How it works
// - Interval register at pointer 0x0B, read/write
// - Interval register resets to 0x07
// - Rate changes idle gap, never conversion time
// - One-shot during idle starts sequence immediately
// - Codes 0..7 give 1/16 to 8 per second
// - Code 6 slows with three or four channels
// - Code 7 slows with two or more channels
// - Local, ext1, ext2, ext3, shutdown, then idle
// - Shutdown stops looping; one-shot runs one sequence
// - Enable bits 3..6 select taking part channels
`timescale 1ns/1ns
`default_nettype none
module conversion_rate_scheduler (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire rate_sched_pkg::reg_req_type i_reg_req,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_rvalid,
    output rate_sched_pkg::conv_ctrl_type o_conv,
    output logic o_stop_converting
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] update_interval_select;
    logic [7:0] stop_ctrl;
    logic [7:0] chan_enable;
    logic one_shot_req;
    logic stop_converting;
    logic [3:0] chan_on;
    rate_sched_pkg::sched_state_type state;
    logic [1:0] channel;
    logic [2:0] active_count;
    logic started_one_shot;

    assign stop_converting = stop_ctrl[rate_sched_pkg::STOP_BIT];
    assign chan_on = chan_enable[rate_sched_pkg::LOCAL_ON_BIT +: rate_sched_pkg::NUM_CHANNELS];

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            update_interval_select <= rate_sched_pkg::RST_INTERVAL;
            stop_ctrl <= rate_sched_pkg::RST_STOP_CTRL;
            chan_enable <= rate_sched_pkg::RST_CHAN_ENABLE;
        end else if (i_ce && i_reg_req.write) begin
            unique case (i_reg_req.pointer)
                rate_sched_pkg::PTR_INTERVAL:
                    update_interval_select <= i_reg_req.wdata & rate_sched_pkg::INTERVAL_MASK;
                rate_sched_pkg::PTR_STOP_CTRL:
                    stop_ctrl <= i_reg_req.wdata & rate_sched_pkg::STOP_CTRL_MASK;
                rate_sched_pkg::PTR_CHAN_ENABLE:
                    chan_enable <= i_reg_req.wdata & rate_sched_pkg::CHAN_ENABLE_MASK;
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_reg_rdata <= 8'h00;
            o_reg_rvalid <= 1'b0;
        end else if (i_ce) begin
            o_reg_rvalid <= i_reg_req.read;
            if (i_reg_req.read) begin
                unique case (i_reg_req.pointer)
                    rate_sched_pkg::PTR_INTERVAL: o_reg_rdata <= update_interval_select;
                    rate_sched_pkg::PTR_STOP_CTRL: o_reg_rdata <= stop_ctrl;
                    rate_sched_pkg::PTR_CHAN_ENABLE: o_reg_rdata <= chan_enable;
                    default: o_reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    // One-shot: any write to its pointer; held while converting, cleared on the next idle or wait cycle
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            one_shot_req <= 1'b0;
        end else if (i_ce) begin
            if (i_reg_req.write && i_reg_req.pointer == rate_sched_pkg::PTR_ONE_SHOT) begin
                one_shot_req <= 1'b1;
            end else if (state != rate_sched_pkg::ST_CONVERT) begin
                one_shot_req <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Idle gap computation
    // ------------------------------------------------------------
    logic [rate_sched_pkg::CNT_W-1:0] seq_period;
    logic [rate_sched_pkg::CNT_W-1:0] busy_time;
    logic [rate_sched_pkg::CNT_W-1:0] idle_count;

    always_comb begin
        active_count = 3'(chan_on[0]) + 3'(chan_on[1]) + 3'(chan_on[2]) + 3'(chan_on[3]);
    end

    // Period halves per code; conversion time never scaled
    assign seq_period = rate_sched_pkg::CNT_W'(rate_sched_pkg::SLOWEST_PERIOD_CYCLES >> update_interval_select[2:0]);
    assign busy_time = rate_sched_pkg::CNT_W'(rate_sched_pkg::CONV_CYCLES) * rate_sched_pkg::CNT_W'(active_count);
    // Too many channels: no idle, rate falls to 8/n per second
    assign idle_count = (seq_period > busy_time) ? seq_period - busy_time : '0;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    logic conv_load;
    logic conv_expired;
    logic idle_load;
    logic idle_expired;
    logic idle_running;
    logic [1:0] next_channel;
    logic next_found;
    logic first_found;
    logic [1:0] first_channel;

    always_comb begin
        next_found = 1'b0;
        next_channel = channel;
        for (int k = 3; k > 0; k--) begin
            if (k > channel && chan_on[k]) begin
                next_found = 1'b1;
                next_channel = 2'(k);
            end
        end
        first_found = 1'b0;
        first_channel = 2'd0;
        for (int k = 3; k >= 0; k--) begin
            if (chan_on[k]) begin
                first_found = 1'b1;
                first_channel = 2'(k);
            end
        end
    end

    logic may_start;
    assign may_start = first_found && (one_shot_req || !stop_converting);

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= rate_sched_pkg::ST_IDLE;
            channel <= 2'd0;
            started_one_shot <= 1'b0;
        end else if (i_ce) begin
            unique case (state)
                rate_sched_pkg::ST_IDLE,
                rate_sched_pkg::ST_WAIT: begin
                    // One-shot cuts the idle gap short
                    if (may_start && (state == rate_sched_pkg::ST_IDLE || one_shot_req || idle_expired)) begin
                        state <= rate_sched_pkg::ST_CONVERT;
                        channel <= first_channel;
                        started_one_shot <= one_shot_req;
                    end else if (state == rate_sched_pkg::ST_WAIT && !idle_running && !idle_load) begin
                        state <= rate_sched_pkg::ST_IDLE;
                    end
                end
                rate_sched_pkg::ST_CONVERT: begin
                    if (conv_expired) begin
                        if (next_found) begin
                            channel <= next_channel;
                        end else begin
                            state <= rate_sched_pkg::ST_WAIT;
                        end
                    end
                end
                default: state <= rate_sched_pkg::ST_IDLE;
            endcase
        end
    end

    // Shutdown halts after the current sequence; gap skipped
    assign idle_load = (state == rate_sched_pkg::ST_CONVERT) && conv_expired && !next_found && !stop_converting;
    assign conv_load = ((state != rate_sched_pkg::ST_CONVERT) &&
                        may_start && (state == rate_sched_pkg::ST_IDLE || one_shot_req || idle_expired)) ||
                       ((state == rate_sched_pkg::ST_CONVERT) && conv_expired && next_found);

    period_timer conv_timer (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_load(conv_load),
        .i_count(rate_sched_pkg::CNT_W'(rate_sched_pkg::CONV_CYCLES)),
        .i_abort(1'b0),
        .o_expired(conv_expired),
        .o_running()
    );

    period_timer idle_timer (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_load(idle_load),
        .i_count(idle_count),
        .i_abort(conv_load),
        .o_expired(idle_expired),
        .o_running(idle_running)
    );

    // ------------------------------------------------------------
    // Converter control outputs
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_conv <= '0;
            o_stop_converting <= 1'b0;
        end else if (i_ce) begin
            o_conv.start <= conv_load;
            o_conv.done <= conv_expired;
            o_conv.busy <= (state == rate_sched_pkg::ST_CONVERT) || conv_load;
            if (conv_load) begin
                o_conv.channel <= (state == rate_sched_pkg::ST_CONVERT) ? next_channel : first_channel;
            end
            o_stop_converting <= stop_converting && !started_one_shot;
        end
    end
endmodule
`default_nettype wire

// *** rate_sched_properties.sv ***
// Purpose: Port checks for the conversion rate scheduler
// Assumes: One clock domain, async active low reset
// Notes: Bound to the top module below
`timescale 1ns/1ns
`default_nettype none
module rate_sched_properties (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire rate_sched_pkg::reg_req_type i_reg_req,
    input wire logic [7:0] o_reg_rdata,
    input wire logic o_reg_rvalid,
    input wire rate_sched_pkg::conv_ctrl_type o_conv,
    input wire logic o_stop_converting
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    // ----
    // Register answers
    // ----
    read_answered_a: assert property (i_ce && i_reg_req.read |=> o_reg_rvalid)
        else $error("read not answered next cycle");
    answer_cause_a: assert property ($rose(o_reg_rvalid) |-> $past(i_reg_req.read && i_ce))
        else $error("read answer without a read");
    interval_codes_a: assert property (i_ce && i_reg_req.read &&
        i_reg_req.pointer == rate_sched_pkg::PTR_INTERVAL
        |=> o_reg_rdata[7:3] == 5'h00) else $error("interval code out of range");
    enable_bits_a: assert property (i_ce && i_reg_req.read &&
        i_reg_req.pointer == rate_sched_pkg::PTR_CHAN_ENABLE
        |=> (o_reg_rdata & ~rate_sched_pkg::CHAN_ENABLE_MASK) == 8'h00) else $error("enable reserved bits set");
    stop_bits_a: assert property (i_ce && i_reg_req.read &&
        i_reg_req.pointer == rate_sched_pkg::PTR_STOP_CTRL
        |=> (o_reg_rdata & ~rate_sched_pkg::STOP_CTRL_MASK) == 8'h00) else $error("stop reserved bits set");
    // ----
    // Conversion sequencing
    // ----
    start_busy_a: assert property (o_conv.start |-> o_conv.busy)
        else $error("start without busy");
    start_pulse_a: assert property (o_conv.start && i_ce |=> (!o_conv.start && !o_conv.done) [*8])
        else $error("conversion shorter than fixed time");
    channel_held_a: assert property (o_conv.busy && !o_conv.start && $past(o_conv.busy)
        |-> $stable(o_conv.channel)) else $error("channel changed mid conversion");
endmodule
bind conversion_rate_scheduler rate_sched_properties chk (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_ce(i_ce),
    .i_reg_req(i_reg_req), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .o_conv(o_conv),
    .o_stop_converting(o_stop_converting));
`default_nettype wire

// *** serial_host_model.sv ***
// Purpose: Host side issuing decoded register accesses
// Assumes: One-cycle request pulses on the system clock
// Notes: Idle request fields carry junk, not the last value
`timescale 1ns/1ns
`default_nettype none
module serial_host_model (
    input wire logic i_sys_clk,
    output var rate_sched_pkg::reg_req_type o_req
);
    initial o_req = '0;
    task automatic access(input logic wr, input logic [7:0] ptr, input logic [7:0] data);
        @(posedge i_sys_clk);
        o_req <= {wr, ~wr, ptr, data};
        @(posedge i_sys_clk);
        o_req <= {1'b0, 1'b0, ~ptr, ~data};
    endtask
    task automatic write_interval(input logic [7:0] code);
        access(1'b1, rate_sched_pkg::PTR_INTERVAL, code & rate_sched_pkg::INTERVAL_MASK);
    endtask
endmodule
`default_nettype wire

// *** conversion_rate_scheduler_tb.sv ***
// Purpose: Self-checking bench for the conversion rate scheduler
// Assumes: Full-length conversions too long to finish here
// Notes: Read expectations queued, compared on answer
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin error_cnt++; \
    $display("BAD %s expected %h seen %h", nm, ex, got); end end
module conversion_rate_scheduler_tb;
    logic i_sys_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_ce = 1'b1;
    rate_sched_pkg::reg_req_type req;
    logic [7:0] o_reg_rdata;
    logic o_reg_rvalid;
    rate_sched_pkg::conv_ctrl_type o_conv;
    logic o_stop_converting;
    logic [7:0] exp_q[$];
    logic [7:0] exp_v;
    logic [7:0] oldest;
    logic [31:0] seed = 32'hBF6A;
    int error_cnt = 0;
    int tests_run = 0;
    always #2 i_sys_clk = ~i_sys_clk;
    serial_host_model host (.i_sys_clk(i_sys_clk), .o_req(req));
    conversion_rate_scheduler uut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_reg_req(req),
        .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .o_conv(o_conv),
        .o_stop_converting(o_stop_converting));
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic rd_exp(input logic [7:0] ptr, input logic [7:0] ex);
        exp_q.push_back(ex);
        host.access(1'b0, ptr, 8'h00);
    endtask
    task automatic drain(input string nm);
        repeat (3) @(posedge i_sys_clk);
        `CHK("pending reads", 0, exp_q.size())
        $display("%s done", nm);
    endtask
    // ----
    // Answer monitor
    // ----
    always @(posedge i_sys_clk) begin
        if (o_reg_rvalid === 1'b1) begin
            if (exp_q.size() == 0) begin
                `CHK("unexpected answer", 1'b0, 1'b1)
            end else begin
                oldest = exp_q.pop_front();
                `CHK("read data", oldest, o_reg_rdata)
            end
        end
    end
    initial begin
        repeat (3000) @(posedge i_sys_clk);
        `CHK("watchdog", 1'b0, 1'b1)
        end_of_test();
    end
    // ----
    // Main sequence
    // ----
    initial begin
        repeat (4) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        for (int k = 0; k < 10 && o_conv.start !== 1'b1; k++)
            @(posedge i_sys_clk);
        `CHK("first channel", 2'd0, o_conv.channel)
        `CHK("busy", 1'b1, o_conv.busy)
        rd_exp(rate_sched_pkg::PTR_INTERVAL, rate_sched_pkg::RST_INTERVAL);
        rd_exp(rate_sched_pkg::PTR_STOP_CTRL, rate_sched_pkg::RST_STOP_CTRL);
        rd_exp(rate_sched_pkg::PTR_CHAN_ENABLE, rate_sched_pkg::RST_CHAN_ENABLE);
        drain("reset values");
        for (int i = 0; i < 12; i++) begin
            seed = lfsr_next(seed);
            exp_v = (i < 8) ? 8'(i) : seed[7:0];
            host.write_interval(exp_v);
            rd_exp(rate_sched_pkg::PTR_INTERVAL, exp_v & rate_sched_pkg::INTERVAL_MASK);
        end
        drain("interval codes");
        host.access(1'b1, rate_sched_pkg::PTR_STOP_CTRL, 8'hFF);
        rd_exp(rate_sched_pkg::PTR_STOP_CTRL, rate_sched_pkg::STOP_CTRL_MASK);
        `CHK("stop flag", 1'b1, o_stop_converting)
        host.access(1'b1, rate_sched_pkg::PTR_STOP_CTRL, 8'h00);
        seed = lfsr_next(seed);
        host.access(1'b1, rate_sched_pkg::PTR_CHAN_ENABLE, seed[7:0]);
        `CHK("stop flag", 1'b0, o_stop_converting)
        rd_exp(rate_sched_pkg::PTR_CHAN_ENABLE, seed[7:0] & rate_sched_pkg::CHAN_ENABLE_MASK);
        host.access(1'b1, 8'h0C, 8'hFF);
        rd_exp(8'h0C, 8'h00);
        rd_exp(rate_sched_pkg::PTR_INTERVAL, exp_v & rate_sched_pkg::INTERVAL_MASK);
        drain("masks and unmapped");
        host.access(1'b1, rate_sched_pkg::PTR_ONE_SHOT, seed[15:8]);
        repeat (2) @(posedge i_sys_clk);
        `CHK("one-shot mid sequence", 1'b0, o_conv.start)
        `CHK("still busy", 1'b1, o_conv.busy)
        @(posedge i_sys_clk);
        i_ce <= 1'b0;
        host.access(1'b0, rate_sched_pkg::PTR_INTERVAL, 8'h00);
        @(posedge i_sys_clk);
        `CHK("frozen answer", 1'b0, o_reg_rvalid)
        i_ce <= 1'b1;
        drain("clock enable");
        end_of_test();
    end
endmodule
`default_nettype wire
